// ---- include/ccpr_pkg.sv ----
`default_nettype none
package ccpr_pkg;

    // ==========================================================
    // register byte offsets (low eight address bits)
    localparam logic [7:0] OFS_POSITION  = 8'h90;
    localparam logic [7:0] OFS_PAL0_LIVE = 8'h9c;
    localparam logic [7:0] OFS_PAL1_SET  = 8'ha0;
    localparam logic [7:0] OFS_PAL1_LIVE = 8'ha4;
    localparam logic [7:0] OFS_PAL2_SET  = 8'ha8;
    localparam logic [7:0] OFS_PAL2_LIVE = 8'hac;
    localparam logic [7:0] OFS_STATUS    = 8'hb8;
    localparam logic [7:0] OFS_MODE      = 8'hbc;
    localparam int         OFS_BITS      = 8;

    // ==========================================================
    // colour field layout
    localparam int COLOR_W = 24;
    localparam int RED_HI  = 23;
    localparam int RED_LO  = 16;
    localparam int GRN_HI  = 15;
    localparam int GRN_LO  = 8;
    localparam int BLU_HI  = 7;
    localparam int BLU_LO  = 0;

    localparam logic [COLOR_W-1:0] COLOR_RESET = 24'h00_0000;
    localparam logic [7:0]         RSVD_BYTE   = 8'h00;
    localparam logic [31:0]        WORD_ZERO   = 32'h0000_0000;
    localparam logic [7:0]         MASK_5BIT   = 8'h1f;
    localparam logic [7:0]         MASK_6BIT   = 8'h3f;
    localparam logic [7:0]         BYTE_ZERO   = 8'h00;

    // ==========================================================
    // status and mode register fields
    localparam int STATUS_ARMED_BIT = 0;
    localparam int STATUS_RUN_BIT   = 1;
    localparam int MODE_DEPTH_LO    = 0;
    localparam int MODE_DEPTH_HI    = 1;
    localparam int MODE_LUT_BIT     = 2;
    localparam int MODE_W           = 3;
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

    typedef enum logic [1:0]
    {
        CCPR_DEPTH_24 = 2'h0,
        CCPR_DEPTH_16 = 2'h1,
        CCPR_DEPTH_8  = 2'h2
    } ccpr_depth_t;

    // pointer image codes that pick colours 1 and 2
    localparam logic [1:0] CODE_PAL1 = 2'h1;
    localparam logic [1:0] CODE_PAL2 = 2'h2;

    // trims a colour to the bits the pixel depth uses
    function automatic logic [COLOR_W-1:0] ccpr_format
    (
        input logic [COLOR_W-1:0] color,
        input logic [1:0]         depth
    );
        logic [COLOR_W-1:0] res;
        res = color;
        case (depth)
            CCPR_DEPTH_16:
            begin
                res[RED_HI:RED_LO] = color[RED_HI:RED_LO] & MASK_5BIT;
                res[GRN_HI:GRN_LO] = color[GRN_HI:GRN_LO] & MASK_6BIT;
                res[BLU_HI:BLU_LO] = color[BLU_HI:BLU_LO] & MASK_5BIT;
            end
            CCPR_DEPTH_8:
            begin
                res[RED_HI:RED_LO] = BYTE_ZERO;
                res[GRN_HI:GRN_LO] = BYTE_ZERO;
            end
            default:
            begin
                res = color;
            end
        endcase
        return res;
    endfunction

endpackage
`default_nettype wire

// ---- logic/ccpr_color_slot.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccpr_color_slot
    import ccpr_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_write,
    input  wire logic [COLOR_W-1:0] i_wdata,
    input  wire logic               i_running,
    input  wire logic               i_transfer,
    output var  logic [COLOR_W-1:0] o_held,
    output var  logic [COLOR_W-1:0] o_live
);

    // ==========================================================
    // holding stage
    // write lands here
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_held <= COLOR_RESET;
        end
        else if (i_write)
        begin
            o_held <= i_wdata;
        end
    end

    // ==========================================================
    // in-effect copy
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_live <= COLOR_RESET;
        end
        else if (i_write && !i_running)
        begin
            o_live <= i_wdata;
        end
        else if (i_transfer)
        begin
            o_live <= o_held;
        end
    end

endmodule
`default_nettype wire

// ---- logic/ccpr_regs.sv ----
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ccpr_regs
    import ccpr_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [ADDR_W-1:0]  i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output var  logic [31:0]        o_prdata,
    output var  logic               o_pready,
    output var  logic               o_pslverr,
    input  wire logic               i_vblank,
    input  wire logic               i_display_ctrl_running,
    input  wire logic [COLOR_W-1:0] i_pointer_pal0_live,
    input  wire logic               i_pointer_2bpp,
    input  wire logic [1:0]         i_pointer_code,
    output var  logic               o_pointer_trigger_armed,
    output var  logic [COLOR_W-1:0] o_pointer_pal1_live,
    output var  logic [COLOR_W-1:0] o_pointer_pal2_live,
    output var  logic [COLOR_W-1:0] o_pointer_pixel,
    output var  logic               o_pointer_pixel_valid,
    output var  logic               o_pointer_via_lut
);

    // ==========================================================
    // elaboration checks
    if (ADDR_W < OFS_BITS || ADDR_W > 32)
    begin : g_bad_addr
        $error("ADDR_W must lie between 8 and 32");
    end

    // ==========================================================
    // declarations
    logic               vb_q1;
    logic               vb_q2;
    logic               vb_q3;
    logic               vb_level;
    logic               vb_rise;
    logic               run_q1;
    logic               run_q2;
    logic               run_q3;
    logic               running;
    logic               pointer_trigger_armed;
    logic [MODE_W-1:0]  mode;
    logic [1:0]         depth;
    logic               lut_enable;
    logic               transfer;
    logic               setup;
    logic               access;
    logic               wr;
    logic               hi_zero;
    logic [7:0]         ofs;
    logic               mapped;
    logic [31:0]        next_rdata;
    logic               wr_position;
    logic               wr_pal1;
    logic               wr_pal2;
    logic               wr_mode;
    logic [COLOR_W-1:0] pal1_held;
    logic [COLOR_W-1:0] pal1_live;
    logic [COLOR_W-1:0] pal2_held;
    logic [COLOR_W-1:0] pal2_live;
    logic [COLOR_W-1:0] pal1_fmt;
    logic [COLOR_W-1:0] pal2_fmt;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            vb_q1 <= 1'b0;
            vb_q2 <= 1'b0;
            vb_q3 <= 1'b0;
        end
        else
        begin
            vb_q1 <= i_vblank;
            vb_q2 <= vb_q1;
            vb_q3 <= vb_q2;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            run_q1 <= 1'b0;
            run_q2 <= 1'b0;
            run_q3 <= 1'b0;
        end
        else
        begin
            run_q1 <= i_display_ctrl_running;
            run_q2 <= run_q1;
            run_q3 <= run_q2;
        end
    end

    // a level counts once stages two and three agree
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            vb_level <= 1'b0;
            running  <= 1'b0;
        end
        else
        begin
            if (vb_q2 == vb_q3)
            begin
                vb_level <= vb_q3;
            end
            if (run_q2 == run_q3)
            begin
                running <= run_q3;
            end
        end
    end

    assign vb_rise = vb_q2 && vb_q3 && !vb_level;

    // ==========================================================
    // apb decode
    assign setup   = i_psel && !i_penable;
    assign access  = i_psel && i_penable && o_pready;
    assign wr      = access && i_pwrite;
    assign hi_zero = (i_paddr >> OFS_BITS) == '0;
    assign ofs     = i_paddr[OFS_BITS-1:0];

    always_comb
    begin
        mapped     = hi_zero;
        next_rdata = WORD_ZERO;
        case (ofs)
            OFS_POSITION:
            begin
                next_rdata = WORD_ZERO;
            end
            OFS_PAL0_LIVE:
            begin
                next_rdata = {RSVD_BYTE, i_pointer_pal0_live};
            end
            OFS_PAL1_SET:
            begin
                next_rdata = {RSVD_BYTE, pal1_held};
            end
            OFS_PAL1_LIVE:
            begin
                next_rdata = {RSVD_BYTE, pal1_live};
            end
            OFS_PAL2_SET:
            begin
                next_rdata = {RSVD_BYTE, pal2_held};
            end
            OFS_PAL2_LIVE:
            begin
                next_rdata = {RSVD_BYTE, pal2_live};
            end
            OFS_STATUS:
            begin
                next_rdata[STATUS_ARMED_BIT] = pointer_trigger_armed;
                next_rdata[STATUS_RUN_BIT]   = running;
            end
            OFS_MODE:
            begin
                next_rdata[MODE_W-1:0] = mode;
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
        if (!mapped)
        begin
            next_rdata = WORD_ZERO;
        end
    end

    // one wait-free access phase; answer registered in setup
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= WORD_ZERO;
        end
        else if (setup)
        begin
            o_pready  <= 1'b1;
            o_pslverr <= !mapped;
            o_prdata  <= i_pwrite ? WORD_ZERO : next_rdata;
        end
        else if (access)
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= WORD_ZERO;
        end
    end

    assign wr_position = wr && mapped && ofs == OFS_POSITION;
    assign wr_pal1     = wr && mapped && ofs == OFS_PAL1_SET;
    assign wr_pal2     = wr && mapped && ofs == OFS_PAL2_SET;
    assign wr_mode     = wr && mapped && ofs == OFS_MODE;

    // ==========================================================
    // trigger armed flag
    assign transfer = vb_rise && pointer_trigger_armed && running;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pointer_trigger_armed <= 1'b0;
        end
        else if (wr_position)
        begin
            pointer_trigger_armed <= 1'b1;
        end
        else if (transfer)
        begin
            pointer_trigger_armed <= 1'b0;
        end
    end

    // ==========================================================
    // mode register
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mode <= MODE_RESET;
        end
        else if (wr_mode)
        begin
            mode <= i_pwdata[MODE_W-1:0];
        end
    end

    assign depth      = mode[MODE_DEPTH_HI:MODE_DEPTH_LO];
    assign lut_enable = mode[MODE_LUT_BIT];

    // ==========================================================
    // colour slots
    // colour fields from write data; top byte dropped
    ccpr_color_slot u_pal1
    (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_write    (wr_pal1),
        .i_wdata    (i_pwdata[COLOR_W-1:0]),
        .i_running  (running),
        .i_transfer (transfer),
        .o_held     (pal1_held),
        .o_live     (pal1_live)
    );

    ccpr_color_slot u_pal2
    (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_write    (wr_pal2),
        .i_wdata    (i_pwdata[COLOR_W-1:0]),
        .i_running  (running),
        .i_transfer (transfer),
        .o_held     (pal2_held),
        .o_live     (pal2_live)
    );

    // ==========================================================
    // pixel path
    // depth trimming
    assign pal1_fmt = ccpr_format(pal1_live, depth);
    assign pal2_fmt = ccpr_format(pal2_live, depth);

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pointer_pal1_live <= COLOR_RESET;
            o_pointer_pal2_live <= COLOR_RESET;
        end
        else
        begin
            o_pointer_pal1_live <= pal1_fmt;
            o_pointer_pal2_live <= pal2_fmt;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pointer_pixel       <= COLOR_RESET;
            o_pointer_pixel_valid <= 1'b0;
        end
        else if (i_pointer_2bpp && i_pointer_code == CODE_PAL1)
        begin
            o_pointer_pixel       <= pal1_fmt;
            o_pointer_pixel_valid <= 1'b1;
        end
        else if (i_pointer_2bpp && i_pointer_code == CODE_PAL2)
        begin
            o_pointer_pixel       <= pal2_fmt;
            o_pointer_pixel_valid <= 1'b1;
        end
        else
        begin
            o_pointer_pixel       <= COLOR_RESET;
            o_pointer_pixel_valid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pointer_via_lut       <= 1'b0;
            o_pointer_trigger_armed <= 1'b0;
        end
        else
        begin
            o_pointer_via_lut       <= lut_enable;
            o_pointer_trigger_armed <= pointer_trigger_armed;
        end
    end

endmodule
`default_nettype wire

// ---- tb/ccpr_regs_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ccpr_regs_checker
    import ccpr_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic               i_clk,
    input wire logic               i_rstn,
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic               i_pwrite,
    input wire logic [ADDR_W-1:0]  i_paddr,
    input wire logic [31:0]        i_pwdata,
    input wire logic [31:0]        o_prdata,
    input wire logic               o_pready,
    input wire logic               o_pslverr,
    input wire logic               i_vblank,
    input wire logic               i_pointer_2bpp,
    input wire logic [1:0]         i_pointer_code,
    input wire logic               o_pointer_trigger_armed,
    input wire logic [COLOR_W-1:0] o_pointer_pal1_live,
    input wire logic [COLOR_W-1:0] o_pointer_pixel,
    input wire logic               o_pointer_pixel_valid,
    input wire logic               o_pointer_via_lut
);
    // ==========================================================
    // completed writes
    logic wr_done;
    logic wr_pos;
    logic wr_mode;
    logic lut_bit;
    assign wr_done = i_psel && i_penable && i_pwrite && o_pready;
    assign wr_pos  = wr_done && (i_paddr == ADDR_W'(OFS_POSITION));
    assign wr_mode = wr_done && (i_paddr == ADDR_W'(OFS_MODE));
    assign lut_bit = i_pwdata[MODE_LUT_BIT];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // ==========================================================
    // properties
    chk_pready_pulse: assert property
        ((i_psel && !i_penable) |=> o_pready ##1 !o_pready) else $error("pready not one access cycle");
    chk_err_ready: assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
    chk_idle_zero: assert property (!o_pready |-> o_prdata == WORD_ZERO) else $error("read data outside access");
    chk_rsvd_zero: assert property
        (o_pready |-> o_prdata[31:24] == RSVD_BYTE) else $error("reserved byte not zero");
    chk_arm_on_pos: assert property (wr_pos |-> ##2 o_pointer_trigger_armed) else $error("armed not set");
    chk_armed_holds: assert property
        (((!i_vblank) [*4] ##0 o_pointer_trigger_armed) |=> o_pointer_trigger_armed) else $error("armed lost");
    chk_pix_pal1: assert property
        ((i_pointer_2bpp && i_pointer_code == CODE_PAL1) |=> o_pointer_pixel_valid
            && o_pointer_pixel == o_pointer_pal1_live) else $error("pixel not colour 1");
    chk_pix_none: assert property
        (!i_pointer_2bpp |=> !o_pointer_pixel_valid && o_pointer_pixel == COLOR_RESET) else $error("stray pixel");
    chk_lut_copy: assert property
        (wr_mode |-> ##2 o_pointer_via_lut == $past(lut_bit, 2)) else $error("lookup flag wrong");
endmodule

bind ccpr_regs ccpr_regs_checker #(.ADDR_W(ADDR_W)) i_chk
(
    .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_vblank(i_vblank), .i_pointer_2bpp(i_pointer_2bpp),
    .i_pointer_code(i_pointer_code), .o_pointer_trigger_armed(o_pointer_trigger_armed),
    .o_pointer_pal1_live(o_pointer_pal1_live), .o_pointer_pixel(o_pointer_pixel),
    .o_pointer_pixel_valid(o_pointer_pixel_valid), .o_pointer_via_lut(o_pointer_via_lut)
);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ccpr_pkg::*;
;
    localparam int           AW = 12;
    localparam logic [31:0]  M  = 32'h00ff_ffff;
    localparam logic [32:0]  ER = 33'h1_0000_0000;
    localparam logic [7:0]   RST_A [5] = '{OFS_PAL1_SET, OFS_PAL1_LIVE, OFS_PAL2_SET, OFS_PAL2_LIVE, OFS_MODE};
    localparam logic [2:0]   MODES [4] = '{3'h1, 3'h2, 3'h7, 3'h4};
    localparam logic [23:0]  MASKS [4] = '{24'h1f_3f1f, 24'h00_00ff, 24'hff_ffff, 24'hff_ffff};

    logic          i_clk   = 1'b0;
    logic          i_rstn  = 1'b0;
    logic          psel    = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite  = 1'b0;
    logic [AW-1:0] paddr   = 12'h000;
    logic [31:0]   pwdata  = 32'h0000_0000;
    logic          vblank  = 1'b0;
    logic          running = 1'b0;
    logic [23:0]   pal0    = 24'h00_0000;
    logic          bpp2    = 1'b0;
    logic [1:0]    code    = 2'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          armed;
    logic [23:0]   pal1;
    logic [23:0]   pal2;
    logic [23:0]   pix;
    logic          pix_v;
    logic          via_lut;
    logic [32:0]   exp_q [$];
    int            n_errors = 0;
    int            n_checks = 0;
    logic [31:0]   rnd = 32'hc614_d85b;
    logic [31:0]   v1;
    logic [31:0]   v2;
    logic [31:0]   v3;

    always #25 i_clk = ~i_clk;

    ccpr_regs #(.ADDR_W(AW)) i_dut
    (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_vblank(vblank), .i_display_ctrl_running(running), .i_pointer_pal0_live(pal0),
        .i_pointer_2bpp(bpp2), .i_pointer_code(code), .o_pointer_trigger_armed(armed),
        .o_pointer_pal1_live(pal1), .o_pointer_pal2_live(pal2), .o_pointer_pixel(pix),
        .o_pointer_pixel_valid(pix_v), .o_pointer_via_lut(via_lut)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        n_checks++;
        if (seen !== want)
        begin
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
            n_errors++;
        end
    endtask

    task automatic close_out;
        // answers never seen count as a single mismatch, however many
        if (exp_q.size() != 0)
            n_errors++;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic [32:0] want);
        exp_q.push_back(want);
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= AW'(a);
        pwdata  <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        // wait until pready is seen high; the watchdog ends it if pready never comes
        do
        begin
            @(posedge i_clk);
        end
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0000_0000, {1'b0, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 33'h0_0000_0000);
    endtask

    task automatic vb;
        @(posedge i_clk);
        vblank <= 1'b1;
        tick(4);
        vblank <= 1'b0;
        tick(6);
    endtask

    // ==========================================================
    // response monitor
    always @(posedge i_clk)
    begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
            check({pslverr, prdata}, exp_q.pop_front());
    end

    initial
    begin
        tick(2000);
        n_errors++;
        close_out;
    end

    // ==========================================================
    // scenarios
    initial
    begin
        tick(8);
        i_rstn <= 1'b1;
        for (int i = 0; i < 5; i++)
            rd(RST_A[i], 32'h0000_0000);
        apb(8'hc0, 1'b1, 32'h0000_0000, ER);
        apb(8'ha1, 1'b0, 32'h0000_0000, ER);
        rnd = lfsr(rnd);
        v1 = rnd;
        pal0 <= v1[31:8];
        wr(OFS_PAL1_SET, v1);
        rd(OFS_PAL1_SET, v1 & M);
        rd(OFS_PAL1_LIVE, v1 & M);
        wr(OFS_PAL1_LIVE, ~v1);
        rd(OFS_PAL1_LIVE, v1 & M);
        rd(OFS_PAL0_LIVE, {8'h00, pal0});
        running <= 1'b1;
        tick(6);
        rnd = lfsr(rnd);
        v2 = rnd;
        rnd = lfsr(rnd);
        v3 = rnd;
        wr(OFS_PAL1_SET, v2);
        wr(OFS_PAL2_SET, v3);
        rd(OFS_PAL1_SET, v2 & M);
        rd(OFS_PAL1_LIVE, v1 & M);
        vb;
        rd(OFS_PAL1_LIVE, v1 & M);
        wr(OFS_POSITION, rnd);
        rd(OFS_STATUS, 32'h0000_0003);
        check(33'(armed), 33'h0_0000_0001);
        vb;
        rd(OFS_PAL1_LIVE, v2 & M);
        rd(OFS_PAL2_LIVE, v3 & M);
        rd(OFS_STATUS, 32'h0000_0002);
        check(33'(armed), 33'h0_0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_MODE, 32'(MODES[i]));
            tick(3);
            check(33'(pal1), 33'(v2[23:0] & MASKS[i]));
            check(33'(pal2), 33'(v3[23:0] & MASKS[i]));
            check(33'(via_lut), 33'(MODES[i][2]));
            rd(OFS_MODE, 32'(MODES[i]));
        end
        bpp2 <= 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            code <= 2'(c);
            tick(3);
            check({8'h00, pix_v, pix}, c == 1 ? {9'h001, v2[23:0]} : c == 2 ? {9'h001, v3[23:0]} : 33'h0);
        end
        bpp2 <= 1'b0;
        i_rstn <= 1'b0;
        tick(2);
        i_rstn <= 1'b1;
        rd(OFS_PAL1_SET, 32'h0000_0000);
        rd(OFS_PAL2_LIVE, 32'h0000_0000);
        tick(4);
        close_out;
    end
endmodule
`default_nettype wire
